// ### common/pot_pkg.sv
// shared constants, types and register map of the quad wiper register bank
package pot_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    // wiper settling interval after leaving shutdown
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // shortest supply dip that counts as a brown-out
    localparam int BROWNOUT_NS = 200;
    localparam int BROWNOUT_CYC = (BROWNOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC);
    localparam logic [7:0] BROWNOUT_LIMIT = 8'(BROWNOUT_CYC);

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int NUM_TAPS = 128;
    localparam int SYNC_W = 6;

    // ----------------------------------------------------------------
    // register map and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_WIPER0 = 8'h00;
    localparam logic [7:0] ADDR_WIPER1 = 8'h01;
    localparam logic [7:0] ADDR_WIPER2 = 8'h02;
    localparam logic [7:0] ADDR_WIPER3 = 8'h03;
    localparam logic [7:0] ADDR_ACCESS_CTRL = 8'h10;
    localparam logic [7:0] WIPER_RESET = 8'h40;
    localparam logic [7:0] ACCESS_CTRL_RESET = 8'h40;
    localparam int SHUTDOWN_N_POS = 6;
    localparam logic [6:0] TAP_MID = 7'h40;
    localparam logic [NUM_TAPS-1:0] TAP_MID_ONEHOT = 128'h1 << TAP_MID;

    // ----------------------------------------------------------------
    // serial framing
    // ----------------------------------------------------------------
    // type code of the identification byte; value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h5;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_TAPS-1:0] tap_en; // one switch per tap, bit 0 nearest low terminal
        logic low_tie;               // wiper tied to low terminal, array ends open
    } pot_drive_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

endpackage

// ### src/bit_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '1;
            q_o <= '1;
        end else if (ce_i) begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // bit_sync

// ### src/tap_switch.sv
// tap switch driver of one channel: make-before-break and shutdown tie
`timescale 1ns/1ps
module tap_switch (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [6:0] position_i,
    input wire logic shutdown_i,
    output pot_pkg::pot_drive_t drive_o
);
    import pot_pkg::*;

    logic [NUM_TAPS-1:0] target;
    logic [7:0] settle_cnt;

    // code 0 selects the tap at the low end, each step one tap higher
    assign target = {{(NUM_TAPS-1){1'b0}}, 1'b1} << position_i;

    // ----------------------------------------------------------------
    // switch sequencing
    // ----------------------------------------------------------------
    // a change first closes the new switch, then opens the old one a cycle
    // later, so the wiper never floats between taps
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drive_o.tap_en <= TAP_MID_ONEHOT;
            drive_o.low_tie <= 1'b0;
            settle_cnt <= 8'h00;
        end else if (ce_i) begin
            if (shutdown_i) begin
                drive_o.tap_en <= '0;
                drive_o.low_tie <= 1'b1;
                settle_cnt <= SETTLE_LOAD;
            end else if (settle_cnt != 8'h00) begin
                // hold the tie until the settling interval has run out
                settle_cnt <= settle_cnt - 8'h01;
                if (settle_cnt == 8'h01) begin
                    drive_o.tap_en <= target;
                    drive_o.low_tie <= 1'b0;
                end
            end else if (drive_o.tap_en != target) begin
                if ((drive_o.tap_en & target) == '0) begin
                    drive_o.tap_en <= drive_o.tap_en | target;
                end else begin
                    drive_o.tap_en <= target;
                end
            end
        end
    end
endmodule // tap_switch

// ### src/quad_wiper_register_bank.sv
// register bank, serial slave and tap control of a quad digital potentiometer
//
// Notes on behaviour
// - wiper code 00h picks tap nearest low end, 7fh nearest high end
// - rising codes move the wiper one tap per step, monotonically upward
// - at reset every wiper register holds 40h, the centre tap
// - five volatile 8-bit registers: four wiper positions and access control
// - wiper i answers at address i, access control at 10h
// - access control bit 6 low shuts all channels down together
// - the shutdown bit resets to 1, normal operation
// - entering shutdown leaves wiper registers untouched
// - leaving shutdown returns wipers to stored taps after settling
// - brown-out during shutdown resets all wiper registers to mid-scale
// - address pins give low three slave address bits; only matches engage
// - address, register and data bits are sampled on rising serial clock
// - outgoing data bit changes only after a falling serial clock
// - data line is open drain: pulled low or released, never driven high
// - new tap switch closes before the old one opens
// - master reads and writes full wiper register values
// - identification byte: type code, pin values, direction bit (1 read)
// - device acknowledges id, address and written bytes; master acks reads
// - write lands on ninth clock; extra bytes write following registers
`timescale 1ns/1ps
module quad_wiper_register_bank (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] addr_select_pins_i,
    input wire logic brownout_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic shutdown_o,
    output pot_pkg::pot_drive_t [pot_pkg::NUM_CH-1:0] pot_drive_o
);
    import pot_pkg::*;

    // ----------------------------------------------------------------
    // types and signals
    // ----------------------------------------------------------------
    // one state per byte kind; each owns its ninth clock
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DEV_ID = 5'b00010,
        ST_REG_ADDR = 5'b00100,
        ST_WR_DATA = 5'b01000,
        ST_RD_DATA = 5'b10000
    } link_state_t;

    // synchronised pin levels
    logic [SYNC_W-1:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic [2:0] pins_s;
    logic bo_s;

    // delayed copies and edge strobes
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // byte framing and pointer
    link_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] rx_byte_now;
    logic [7:0] tx_shift;
    logic [7:0] reg_ptr;
    logic ack_pending;
    logic rw_bit;

    // one-cycle write request to the registers
    reg_write_t write_req;

    // register contents and supply filter
    logic [7:0] wiper_position_reg [NUM_CH];
    logic shutdown_n_bit;
    logic [7:0] bo_cnt;
    logic bo_active;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // identification byte: type code, then the three pin levels, then R/W
    // the direction bit is left out, so both directions match
    function automatic logic id_match(input logic [7:0] id, input logic [2:0] pins);
        id_match = (id[7:4] == TYPE_CODE) && (id[3:1] == pins);
    endfunction

    // read-back multiplexer; unmapped addresses read as zero
    // access control shows only the shutdown bit
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        case (addr)
            ADDR_WIPER0: read_reg = wiper_position_reg[0];
            ADDR_WIPER1: read_reg = wiper_position_reg[1];
            ADDR_WIPER2: read_reg = wiper_position_reg[2];
            ADDR_WIPER3: read_reg = wiper_position_reg[3];
            ADDR_ACCESS_CTRL: read_reg = 8'(shutdown_n_bit) << SHUTDOWN_N_POS;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisation and bus condition detection
    // ----------------------------------------------------------------
    // the serial clock is only sampled here; at 20 MHz against a clock low
    // time well above a microsecond, every serial edge is seen
    bit_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .d_i({scl_i, sda_i, addr_select_pins_i, brownout_i}),
        .q_o(sync_q)
    );

    // unpacked in the order the pins were packed
    assign scl_s = sync_q[5];
    assign sda_s = sync_q[4];
    assign pins_s = sync_q[3:1];
    assign bo_s = sync_q[0];

    // previous synchronised levels for edge finding
    // reset to the idle bus level: no false edge after reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce_i) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // data moves only while the clock is low; a data edge with the clock
    // high is a start or a stop
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
    // the byte with the current bit shifted in
    assign rx_byte_now = {shift_in[6:0], sda_s};

    // ----------------------------------------------------------------
    // serial slave protocol
    // ----------------------------------------------------------------
    // bit_cnt counts rising clocks of a byte: 0..7 carry data, 8 is the
    // ninth (acknowledge) clock; the ack decision is taken on the eighth
    // a start or stop outranks a clock edge in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            tx_shift <= 8'h00;
            reg_ptr <= 8'h00;
            ack_pending <= 1'b0;
            rw_bit <= 1'b0;
            sda_oe_o <= 1'b0;
            write_req <= '0;
        end else if (ce_i) begin
            // the write strobe lasts one cycle
            write_req.en <= 1'b0;
            if (start_det) begin
                // a repeated start restarts framing but keeps the pointer
                state <= ST_DEV_ID;
                bit_cnt <= 4'h0;
                ack_pending <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_det) begin
                // a partial byte is dropped
                state <= ST_IDLE;
                ack_pending <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (state != ST_IDLE && scl_rise) begin
                if (bit_cnt != BIT_ACK) begin
                    shift_in <= rx_byte_now;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == BIT_LAST) begin
                        case (state)
                            ST_DEV_ID: begin
                                ack_pending <= id_match(rx_byte_now, pins_s);
                                rw_bit <= rx_byte_now[0];
                            end
                            ST_REG_ADDR: ack_pending <= 1'b1;
                            ST_WR_DATA: ack_pending <= 1'b1;
                            default: ack_pending <= 1'b0;
                        endcase
                    end
                end else begin
                    // ninth clock: act on the completed byte
                    bit_cnt <= 4'h0;
                    ack_pending <= 1'b0;
                    case (state)
                        ST_DEV_ID: begin
                            if (!ack_pending) begin
                                state <= ST_IDLE;
                            end else if (rw_bit) begin
                                state <= ST_RD_DATA;
                                tx_shift <= read_reg(reg_ptr);
                            end else begin
                                state <= ST_REG_ADDR;
                            end
                        end
                        ST_REG_ADDR: begin
                            reg_ptr <= shift_in;
                            state <= ST_WR_DATA;
                        end
                        ST_WR_DATA: begin
                            write_req.en <= 1'b1;
                            write_req.addr <= reg_ptr;
                            write_req.data <= shift_in;
                            reg_ptr <= reg_ptr + 8'h01;
                        end
                        ST_RD_DATA: begin
                            if (sda_s) begin
                                // master nack ends the read; wait for stop
                                state <= ST_IDLE;
                            end else begin
                                reg_ptr <= reg_ptr + 8'h01;
                                tx_shift <= read_reg(reg_ptr + 8'h01);
                            end
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
            end else if (state != ST_IDLE && scl_fall) begin
                // the line only ever changes just after a falling clock
                if (bit_cnt == BIT_ACK) begin
                    sda_oe_o <= ack_pending;
                end else if (state == ST_RD_DATA) begin
                    sda_oe_o <= ~tx_shift[~bit_cnt[2:0]];
                end else begin
                    sda_oe_o <= 1'b0;
                end
            end else if (state == ST_IDLE) begin
                sda_oe_o <= 1'b0;
            end
        end
    end

    // the data pin is never driven high: only pulled low through the enable
    // kept as a flop so every output leaves a register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sda_o <= 1'b0;
        end else if (ce_i) begin
            sda_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // supply brown-out qualification
    // ----------------------------------------------------------------
    // short spikes on the monitor are filtered; only a dip lasting the
    // qualification time counts
    // the count restarts whenever the dip ends
    // trade-off: a real dip is seen a few cycles late
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bo_cnt <= 8'h00;
        end else if (ce_i) begin
            if (!bo_s) begin
                bo_cnt <= 8'h00;
            end else if (bo_cnt != BROWNOUT_LIMIT) begin
                bo_cnt <= bo_cnt + 8'h01;
            end
        end
    end

    // held while the dip lasts, so wipers stay at mid-scale while in shutdown
    assign bo_active = (bo_cnt == BROWNOUT_LIMIT);

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // five volatile bytes; brown-out in shutdown outranks a pending write so
    // the wipers never come back from an undefined value
    // a wiper write in shutdown is kept for the exit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                wiper_position_reg[i] <= WIPER_RESET;
            end
            shutdown_n_bit <= ACCESS_CTRL_RESET[SHUTDOWN_N_POS];
        end else if (ce_i) begin
            if (bo_active && !shutdown_n_bit) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    wiper_position_reg[i] <= WIPER_RESET;
                end
            end else if (write_req.en) begin
                case (write_req.addr)
                    ADDR_WIPER0: wiper_position_reg[0] <= write_req.data;
                    ADDR_WIPER1: wiper_position_reg[1] <= write_req.data;
                    ADDR_WIPER2: wiper_position_reg[2] <= write_req.data;
                    ADDR_WIPER3: wiper_position_reg[3] <= write_req.data;
                    ADDR_ACCESS_CTRL: begin
                        // only the shutdown bit is stored; shutdown keeps wipers
                        shutdown_n_bit <= write_req.data[SHUTDOWN_N_POS];
                    end
                    // unmapped addresses are acked, nothing stored
                    default: shutdown_n_bit <= shutdown_n_bit;
                endcase
            end
        end
    end

    // shutdown state shown on a pin
    // lags the bit by one cycle, in step with the tap drivers on entry; on exit the tie holds until settling ends
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shutdown_o <= 1'b0;
        end else if (ce_i) begin
            shutdown_o <= ~shutdown_n_bit;
        end
    end

    // ----------------------------------------------------------------
    // per-channel tap drivers
    // ----------------------------------------------------------------
    // all channels share the one shutdown control; bit 7 of a wiper
    // register is stored and read back but selects no tap
    // limitation: a code written while settling shows at its end
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            tap_switch u_tap (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .ce_i(ce_i),
                .position_i(wiper_position_reg[ch][6:0]),
                .shutdown_i(~shutdown_n_bit),
                .drive_o(pot_drive_o[ch])
            );
        end
    endgenerate

endmodule // quad_wiper_register_bank

// ### dv/i2c_master_model.sv
// serial bus master model that drives the quad wiper register bank
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // ------------------------------------------------------------
    // bus phases: four system clocks per half period, 400 ns bit time
    // ------------------------------------------------------------
    // sda_o high means released; the pull-up makes the wire high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    // start or repeated start; the clock stands high between frames
    task automatic start();
        sda_o = 1'b1;
        half();
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b0;
        half();
        scl_o = 1'b0;
    endtask
    // data lowered a half after the clock fall, so no false start is seen
    task automatic stop();
        half();
        sda_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b1;
        half();
    endtask
    // eight bits msb first plus acknowledge slot; q holds what the wire showed
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            @(negedge clk_i);
            sda_o = d[i];
            repeat (3) @(negedge clk_i);
            scl_o = 1'b1;
            half();
            q[i] = sda_i;
            scl_o = 1'b0;
        end
    endtask
endmodule // i2c_master_model

// ### dv/quad_wiper_register_bank_sva.sv
// checker of the quad wiper register bank ports
`timescale 1ns/1ps
module quad_wiper_register_bank_sva (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic shutdown_o,
    input wire pot_pkg::pot_drive_t [pot_pkg::NUM_CH-1:0] pot_drive_o
);
    import pot_pkg::*;
    // ------------------------------------------------------------
    // helper logic: previous drive and per-channel health flags
    // ------------------------------------------------------------
    pot_drive_t [NUM_CH-1:0] prev;
    logic [NUM_CH-1:0] tie_ok, cnt_ok, mbb_ok, mid_ok;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev <= {NUM_CH{TAP_MID_ONEHOT, 1'b0}};
        end else begin
            prev <= pot_drive_o;
        end
    end
    // overlap test: a tap change with no common bit leaves the wiper floating
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            tie_ok[c] = pot_drive_o[c].low_tie && pot_drive_o[c].tap_en == '0;
            cnt_ok[c] = pot_drive_o[c].low_tie || $countones(pot_drive_o[c].tap_en) inside {1, 2};
            mbb_ok[c] = pot_drive_o[c].low_tie || prev[c].low_tie ||
                (pot_drive_o[c].tap_en & prev[c].tap_en) != '0;
            mid_ok[c] = pot_drive_o[c].tap_en == TAP_MID_ONEHOT && !pot_drive_o[c].low_tie;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sda_low_only: assert property (!sda_o)
        else $error("data line driven high");
    a_drive_after_fall: assert property ($rose(sda_oe_o) |->
        !scl_i && !$past(scl_i) && !$past(scl_i, 2) && $past(scl_i, 6))
        else $error("data line changed outside clock low");
    a_shut_ties: assert property (shutdown_o && $past(shutdown_o, 2) |-> &tie_ok)
        else $error("channel not tied low in shutdown");
    a_taps_count: assert property (&cnt_ok)
        else $error("tap switch count wrong");
    a_make_first: assert property (&mbb_ok)
        else $error("old tap opened before new tap closed");
    a_settle_hold: assert property ($fell(shutdown_o) |-> ##10 pot_drive_o[0].low_tie)
        else $error("wiper released before settling");
    a_settle_end: assert property ($fell(shutdown_o) |-> ##[15:25] !pot_drive_o[0].low_tie)
        else $error("wiper not released after settling");
    a_reset_mid: assert property ($rose(rst_b_i) |-> &mid_ok && !shutdown_o && !sda_oe_o)
        else $error("reset state wrong");
    c_ack: cover property ($rose(sda_oe_o));
    c_enter: cover property ($rose(shutdown_o));
    c_exit: cover property ($fell(shutdown_o) ##25 !shutdown_o);
endmodule // quad_wiper_register_bank_sva
bind quad_wiper_register_bank quad_wiper_register_bank_sva chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .shutdown_o(shutdown_o),
    .pot_drive_o(pot_drive_o));

// ### dv/testbench.sv
// self-checking bench of the quad wiper register bank
`timescale 1ns/1ps
module testbench;
    import pot_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic bo = 1'b0;
    logic [2:0] pins = 3'h0;
    logic scl, sda_m, sda_oe, sda_low, shut;
    pot_drive_t [NUM_CH-1:0] drv;
    wire sda = sda_m & ~sda_oe; // open drain with pull-up
    int error_cnt = 0;
    int num_checks = 0;
    int mdl [6]; // wipers 0..3, access control 4, unmapped 5
    always #25 clk = ~clk;
    quad_wiper_register_bank dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .scl_i(scl),
        .sda_i(sda), .addr_select_pins_i(pins), .brownout_i(bo), .sda_o(sda_low),
        .sda_oe_o(sda_oe), .shutdown_o(shut), .pot_drive_o(drv));
    i2c_master_model mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    // ------------------------------------------------------------
    // comparison, verdict and reference model helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic int slot(input int a);
        return (a < 4) ? a : (a == 16) ? 4 : 5;
    endfunction
    // identification and register address phase of every access
    task automatic head(input logic [7:0] a);
        logic [8:0] q;
        mst.start();
        mst.xfer({TYPE_CODE, pins, 2'b01}, q);
        chk("id ack", 128'(0), 128'(q[0]));
        mst.xfer({a, 1'b1}, q);
        chk("addr ack", 128'(0), 128'(q[0]));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        logic [8:0] q;
        head(a);
        foreach (d[i]) begin
            mst.xfer({d[i], 1'b1}, q);
            chk("data ack", 128'(0), 128'(q[0]));
            if (slot(a + i) < 5) mdl[slot(a + i)] = (a + i == 16) ? d[i] & 8'h40 : d[i];
        end
        mst.stop();
    endtask
    // pointer keeps counting past the last wiper, unmapped places read zero
    task automatic rd(input logic [7:0] a, input int n);
        logic [8:0] q;
        head(a);
        mst.start();
        mst.xfer({TYPE_CODE, pins, 2'b11}, q);
        chk("read id ack", 128'(0), 128'(q[0]));
        for (int i = 0; i < n; i++) begin
            mst.xfer({8'hff, i == n - 1}, q);
            chk("read data", 128'(mdl[slot(a + i)]), 128'(q[8:1]));
        end
        mst.stop();
    endtask
    task automatic taps();
        for (int c = 0; c < NUM_CH; c++) begin
            chk("tap", mdl[4][6] ? 128'h1 << mdl[c][6:0] : 128'h0, drv[c].tap_en);
            chk("tie", 128'(!mdl[4][6]), 128'(drv[c].low_tie));
        end
        chk("shutdown", 128'(!mdl[4][6]), 128'(shut));
        chk("sda out", 128'(0), 128'(sda_low));
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v[$];
        logic [8:0] q;
        pins = 3'($urandom(32'hdf63));
        foreach (mdl[i]) mdl[i] = (i < 5) ? 8'h40 : 0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        taps();
        rd(8'h00, 5);
        rd(8'h10, 1);
        v = '{8'h00, 8'h7f, 8'($urandom), 8'($urandom), 8'($urandom)};
        wr(8'h00, v);
        repeat (4) @(negedge clk);
        taps();
        rd(8'h00, 4);
        // a supply dip outside shutdown must leave the wipers alone
        bo = 1'b1;
        repeat (10) @(negedge clk);
        bo = 1'b0;
        rd(8'h00, 4);
        for (int k = 0; k < 2; k++) begin
            mst.start();
            mst.xfer(k ? {TYPE_CODE ^ 4'h3, pins, 2'b01} : {TYPE_CODE, ~pins, 2'b01}, q);
            chk("foreign id", 128'(1), 128'(q[0]));
            mst.stop();
        end
        wr(8'h10, '{8'hff});
        rd(8'h10, 1);
        wr(8'h10, '{8'h00});
        repeat (4) @(negedge clk);
        taps();
        rd(8'h00, 4);
        bo = 1'b1;
        repeat (10) @(negedge clk);
        bo = 1'b0;
        for (int c = 0; c < NUM_CH; c++) mdl[c] = 8'h40;
        rd(8'h00, 4);
        wr(8'h03, '{8'($urandom)});
        wr(8'h10, '{8'h40});
        repeat (30) @(negedge clk);
        taps();
        test_done();
    end
    // watchdog: the sequence needs well under a millisecond
    initial begin
        #1000000;
        error_cnt++;
        test_done();
    end
endmodule // testbench
